/* banked_memory_address_decoder.sv */
// Program address generation and banked data memory decoding
`timescale 1ns/100ps
`include "mem_decode_map.svh"

module banked_memory_address_decoder #(
    parameter int RAM_WORDS = 128
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       pc_load,
    input  wire logic [12:0]                pc_load_value,
    input  wire logic                       pc_step,
    input  wire logic                       intr_take,
    output logic [12:0]                     pc_value,
    output logic [10:0]                     fetch_addr,
    input  wire mem_decode_pkg::data_req_t  data_req,
    output logic [7:0]                      rdata,
    output mem_decode_pkg::region_t         region,
    output logic [8:0]                      eff_addr,
    output mem_decode_pkg::special_req_t    special_req,
    input  wire logic [7:0]                 special_rdata,
    input  wire logic [4:0]                 status_flags_in,
    input  wire logic                       status_flags_we
);
    import mem_decode_pkg::*;

    logic [12:0] pc_q;
    logic [12:0] pc_d;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  pointer_q;
    logic [7:0]  pointer_d;
    logic [7:0]  hi_latch_q;
    logic [7:0]  hi_latch_d;
    logic [7:0]  intr_ctl_q;
    logic [7:0]  intr_ctl_d;
    logic [7:0]  ram_q [RAM_WORDS];
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    logic [1:0]  bank;
    logic [6:0]  loc;
    logic [6:0]  ram_idx;
    logic        ram_hit;
    logic        core_hit;
    logic        ram_we;
    logic        status_we;
    logic        pointer_we;
    logic        hi_latch_we;
    logic        intr_ctl_we;
    logic [7:0]  core_rdata;
    logic [7:0]  ram_rdata;

    // Program counter sequencing
    always_comb begin
        pc_d = pc_q;
        if (intr_take) begin
            pc_d = `INTR_VECTOR;
        end else if (pc_load) begin
            pc_d = pc_load_value;
        end else if (pc_step) begin
            pc_d = pc_q + 13'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= `RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign pc_value = pc_q;
    assign fetch_addr = pc_q[`PROG_IMPL_BITS-1:0];

    // Address formation
    always_comb begin
        if (data_req.addr == `OFS_INDIRECT_PORT) begin
            eff_addr = {status_q[`STATUS_IND_BANK], pointer_q};
        end else begin
            eff_addr = {status_q[`STATUS_BANK_HI],
                        status_q[`STATUS_BANK_LO], data_req.addr};
        end
    end

    assign bank = eff_addr[8:7];
    assign loc  = eff_addr[6:0];

    // Region decode
    always_comb begin
        ram_hit  = 1'b0;
        core_hit = 1'b0;
        ram_idx  = loc;
        region   = REGION_NONE;
        if (loc < `SPECIAL_LIMIT) begin
            case (loc)
                `OFS_PC_LOW, `OFS_STATUS, `OFS_POINTER,
                `OFS_PC_HIGH_LATCH, `OFS_INTR_CONTROL: begin
                    core_hit = 1'b1;
                    region   = REGION_CORE;
                end
                `OFS_INDIRECT_PORT: begin
                    region = REGION_NONE;
                end
                default: begin
                    region = REGION_SPECIAL;
                end
            endcase
        end else if (loc >= `ALIAS_BASE) begin
            ram_hit = 1'b1;
            region  = REGION_RAM;
        end else if (bank == 2'b00) begin
            ram_hit = 1'b1;
            region  = REGION_RAM;
        end else if (bank == 2'b01 && loc < `BANK1_RAM_LIMIT) begin
            // bank 1 RAM at A0h-BFh, placed in unused index space
            ram_hit = 1'b1;
            ram_idx = loc - `SPECIAL_LIMIT;
            region  = REGION_RAM;
        end
    end

    assign special_req.valid = (data_req.rd || data_req.wr)
                               && (region == REGION_SPECIAL);
    assign special_req.addr  = eff_addr;
    assign special_req.wdata = data_req.wdata;
    assign ram_we = data_req.wr && ram_hit;

    // Write strobes for the core registers
    always_comb begin
        status_we   = 1'b0;
        pointer_we  = 1'b0;
        hi_latch_we = 1'b0;
        intr_ctl_we = 1'b0;
        if (data_req.wr && core_hit) begin
            case (loc)
                `OFS_STATUS: begin
                    status_we = 1'b1;
                end
                `OFS_POINTER: begin
                    pointer_we = 1'b1;
                end
                `OFS_PC_HIGH_LATCH: begin
                    hi_latch_we = 1'b1;
                end
                `OFS_INTR_CONTROL: begin
                    intr_ctl_we = 1'b1;
                end
                default: begin
                    status_we = 1'b0;
                end
            endcase
        end
    end

    // Next values of the core registers
    always_comb begin
        status_d   = status_q;
        pointer_d  = pointer_q;
        hi_latch_d = hi_latch_q;
        intr_ctl_d = intr_ctl_q;
        // Arithmetic flags come from the core, never from a write
        if (status_flags_we) begin
            status_d[4:0] = status_flags_in;
        end
        // Only the bank bits are writable here
        if (status_we) begin
            status_d[7:5] = data_req.wdata[7:5];
        end
        if (pointer_we) begin
            pointer_d = data_req.wdata;
        end
        // Upper three bits are unimplemented
        if (hi_latch_we) begin
            hi_latch_d = {3'h0, data_req.wdata[4:0]};
        end
        if (intr_ctl_we) begin
            intr_ctl_d = data_req.wdata;
        end
    end

    // Core register read mux
    always_comb begin
        case (loc)
            `OFS_PC_LOW: begin
                core_rdata = pc_q[7:0];
            end
            `OFS_STATUS: begin
                core_rdata = status_q;
            end
            `OFS_POINTER: begin
                core_rdata = pointer_q;
            end
            `OFS_PC_HIGH_LATCH: begin
                core_rdata = hi_latch_q;
            end
            `OFS_INTR_CONTROL: begin
                core_rdata = intr_ctl_q;
            end
            default: begin
                core_rdata = 8'h00;
            end
        endcase
    end

    assign ram_rdata = ram_q[ram_idx];

    // Read data selection, held between reads
    always_comb begin
        rdata_d = rdata_q;
        if (data_req.rd) begin
            rdata_d = 8'h00;
            if (ram_hit) begin
                rdata_d = ram_rdata;
            end else if (region == REGION_SPECIAL) begin
                rdata_d = special_rdata;
            end else if (core_hit) begin
                rdata_d = core_rdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= `STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pointer_q <= `POINTER_RESET;
        end else begin
            pointer_q <= pointer_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_latch_q <= `HI_LATCH_RESET;
        end else begin
            hi_latch_q <= hi_latch_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intr_ctl_q <= `INTR_CTL_RESET;
        end else begin
            intr_ctl_q <= intr_ctl_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // RAM storage has no reset
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram_q[ram_idx] <= data_req.wdata;
        end
    end

    assign rdata = rdata_q;

endmodule // banked_memory_address_decoder

/* mem_decode_map.svh */
// Offsets, field positions, reset values and vectors of the memory decoder
`ifndef MEM_DECODE_MAP_SVH
`define MEM_DECODE_MAP_SVH

`define PC_WIDTH          13
`define PROG_IMPL_BITS    11
`define RESET_VECTOR      13'h0000
`define INTR_VECTOR       13'h0004

`define OFS_INDIRECT_PORT 7'h00
`define OFS_PC_LOW        7'h02
`define OFS_STATUS        7'h03
`define OFS_POINTER       7'h04
`define OFS_PC_HIGH_LATCH 7'h0A
`define OFS_INTR_CONTROL  7'h0B

`define SPECIAL_LIMIT     7'h20
`define ALIAS_BASE        7'h70
`define BANK1_RAM_LIMIT   7'h40

`define STATUS_BANK_LO    5
`define STATUS_BANK_HI    6
`define STATUS_IND_BANK   7

`define STATUS_RESET      8'h18
`define POINTER_RESET     8'h00
`define HI_LATCH_RESET    8'h00
`define INTR_CTL_RESET    8'h00

`endif

/* mem_decode_pkg.sv */
// Types shared by the memory decoder and its users
package mem_decode_pkg;

    typedef enum logic [1:0] {
        REGION_NONE    = 2'b00,
        REGION_CORE    = 2'b01,
        REGION_RAM     = 2'b10,
        REGION_SPECIAL = 2'b11
    } region_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } data_req_t;

    typedef struct packed {
        logic       valid;
        logic [8:0] addr;
        logic [7:0] wdata;
    } special_req_t;

endpackage

/* mem_decode_checker.sv */
// Port assertions for the banked memory decoder
`timescale 1ns/100ps
module mem_decode_checker (
    input wire logic                         core_clk,
    input wire logic                         rst_b,
    input wire logic                         pc_load,
    input wire logic [12:0]                  pc_load_value,
    input wire logic                         pc_step,
    input wire logic                         intr_take,
    input wire logic [12:0]                  pc_value,
    input wire logic [10:0]                  fetch_addr,
    input wire mem_decode_pkg::data_req_t    data_req,
    input wire logic [7:0]                   rdata,
    input wire mem_decode_pkg::region_t      region,
    input wire logic [8:0]                   eff_addr,
    input wire mem_decode_pkg::special_req_t special_req,
    input wire logic [7:0]                   special_rdata
);
    import mem_decode_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic rq;
    assign rq = data_req.rd | data_req.wr;
    AST_FETCH_WRAP: assert property (fetch_addr == pc_value[10:0])
        else $error("fetch address wrong");
    AST_INTR_VEC: assert property (intr_take |=> pc_value == 13'h0004)
        else $error("interrupt vector wrong");
    AST_PC_LOAD: assert property (pc_load && !intr_take
        |=> pc_value == $past(pc_load_value)) else $error("pc load");
    AST_PC_STEP: assert property (pc_step && !pc_load && !intr_take
        |=> pc_value == $past(pc_value) + 13'h0001) else $error("pc step");
    AST_EFF_DIRECT: assert property (rq && data_req.addr != 7'h00
        |-> eff_addr[6:0] == data_req.addr) else $error("direct address");
    AST_CORE_REGS: assert property (rq && data_req.addr inside
        {7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B} |-> region == REGION_CORE)
        else $error("core register region");
    AST_SPEC_VALID: assert property (special_req.valid ==
        (rq && region == REGION_SPECIAL)) else $error("special valid");
    AST_SPEC_LOW: assert property (region == REGION_SPECIAL |->
        eff_addr[6:0] < 7'h20 && special_req.addr == eff_addr)
        else $error("special address");
    AST_SPEC_RD: assert property (data_req.rd && region == REGION_SPECIAL
        |=> rdata == $past(special_rdata)) else $error("special read");
    AST_ZERO_RD: assert property (data_req.rd && region == REGION_NONE
        |=> rdata == 8'h00) else $error("unimplemented read");
endmodule // mem_decode_checker

bind banked_memory_address_decoder mem_decode_checker u_chk (
    .core_clk, .rst_b, .pc_load, .pc_load_value, .pc_step, .intr_take,
    .pc_value, .fetch_addr, .data_req, .rdata, .region, .eff_addr,
    .special_req, .special_rdata);

/* periph_model.sv */
// Peripheral register model answering special register reads
`timescale 1ns/100ps
module periph_model (
    input  wire mem_decode_pkg::special_req_t special_req,
    output logic [7:0]                        special_rdata
);
    import mem_decode_pkg::*;
    assign special_rdata = special_req.valid ?
        special_req.addr[7:0] ^ 8'h5A : ~special_req.addr[7:0];
endmodule // periph_model

/* banked_memory_address_decoder_tb.sv */
// Self-checking bench for the banked memory decoder
`timescale 1ns/100ps
module banked_memory_address_decoder_tb;
    import mem_decode_pkg::*;
    logic         core_clk, rst_b, pc_load, pc_step, intr_take;
    logic [12:0]  pc_load_value, pc_value;
    logic [10:0]  fetch_addr;
    logic [7:0]   rdata, sp_rd;
    data_req_t    data_req;
    special_req_t sp_req;
    logic [31:0]  seed = 32'h00010EB3;
    logic [31:0]  v;
    int           error_cnt = 0, checked = 0;
    banked_memory_address_decoder u_dut (.core_clk, .rst_b, .pc_load,
        .pc_load_value, .pc_step, .intr_take, .pc_value, .fetch_addr,
        .data_req, .rdata, .region(), .eff_addr(), .special_req(sp_req),
        .special_rdata(sp_rd), .status_flags_in(5'h00),
        .status_flags_we(1'b0));
    periph_model u_per (.special_req(sp_req), .special_rdata(sp_rd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] per(input logic [8:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic end_sim();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [12:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic xf(input logic r, w, input logic [6:0] a,
                      input logic [7:0] d);
        @(posedge core_clk);
        data_req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge core_clk);
        data_req <= '0;
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xf(1'b0, 1'b1, a, d);
    endtask
    task automatic rc(input logic [6:0] a, input logic [7:0] e);
        xf(1'b1, 1'b0, a, 8'h00);
        chk("rdata", {5'h00, e}, {5'h00, rdata});
    endtask
    task automatic bk(input logic [2:0] b);
        wr(7'h03, {b, 5'h00});
    endtask
    task automatic pc(input logic i, l, s, input logic [12:0] d);
        @(posedge core_clk);
        {intr_take, pc_load, pc_step, pc_load_value} <= {i, l, s, d};
        @(posedge core_clk);
        {intr_take, pc_load, pc_step} <= 3'b000;
        #1;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        {rst_b, pc_load, pc_step, intr_take} = 4'h0;
        pc_load_value = 13'h0000;
        data_req = '0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        chk("pc", 13'h0000, pc_value);
        rc(7'h03, 8'h18);
        pc(1'b1, 1'b1, 1'b1, 13'h1FFF);
        chk("pc", 13'h0004, pc_value);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            pc(1'b0, 1'b1, 1'b0, v[12:0]);
            chk("fetch", {2'b00, v[10:0]}, {2'b00, fetch_addr});
            v = rnd();
            wr(7'h20 + {1'b0, v[5:0]}, v[15:8]);
            rc(7'h20 + {1'b0, v[5:0]}, v[15:8]);
        end
        pc(1'b0, 1'b1, 1'b0, 13'h1FFF);
        pc(1'b0, 1'b0, 1'b1, 13'h0000);
        chk("pc", 13'h0000, pc_value);
        for (int b = 1; b < 4; b++) begin
            bk(b[2:0]);
            wr(7'h70 + b[6:0], 8'hC0 + b[7:0]);
            bk(3'b000);
            rc(7'h70 + b[6:0], 8'hC0 + b[7:0]);
        end
        bk(3'b001);
        wr(7'h25, 8'h3C);
        wr(7'h40, 8'hFF);
        rc(7'h40, 8'h00);
        bk(3'b000);
        wr(7'h25, 8'hC3);
        bk(3'b001);
        rc(7'h25, 8'h3C);
        bk(3'b010);
        rc(7'h20, 8'h00);
        rc(7'h11, per(9'h111));
        bk(3'b011);
        rc(7'h6F, 8'h00);
        wr(7'h04, 8'h30);
        bk(3'b000);
        rc(7'h04, 8'h30);
        wr(7'h30, 8'h77);
        rc(7'h00, 8'h77);
        wr(7'h00, 8'h99);
        rc(7'h30, 8'h99);
        rc(7'h01, per(9'h001));
        bk(3'b100);
        wr(7'h04, 8'hF3);
        rc(7'h00, 8'hC3);
        end_sim();
    end
endmodule // banked_memory_address_decoder_tb
